// file: bench/pbp_pin_model.sv
// External pins of port B: test drive, pull devices, else a floating line.
// Assumes the block's pull outputs reach this model directly.
`timescale 1ns/1ps
module pbp_pin_model (
  // Clock
  input wire logic clk,
  // Test drive
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // Pad controls
  input wire logic [7:0] pull_on,
  input wire logic [7:0] pull_down,
  // Pins
  output logic [7:0] pin_in
);
  logic float_bit = 1'b0;
  // A floating pin wanders, so a missing pull cannot pass unseen
  always @(posedge clk) begin
    float_bit <= ~float_bit;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pull_on[i])
        pin_in[i] = ~pull_down[i];
      else
        pin_in[i] = float_bit;
    end
  end
endmodule

// file: bench/pbp_port_b_properties.sv
// Checker for the port B pad and pin interrupt block, on its ports only.
// Assumes one AHB-Lite master whose hready is the block's hreadyout.
`timescale 1ns/1ps
module pbp_port_b_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Pads and request
  input wire logic [7:0] output_enable,
  input wire logic [7:0] pull_on,
  input wire logic [7:0] pull_down,
  input wire logic [7:0] slew_on,
  input wire logic [7:0] drive_high,
  input wire logic pin_irq_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic sc_hit;
  logic sc_rd;
  logic sc_wr;
  assign sc_hit = hsel && hready && htrans[1] && haddr[7:0] == pbp_pkg::STATUS_CONTROL_OFS;
  always_ff @(posedge clk) begin
    sc_rd <= !srst && sc_hit && !hwrite;
    sc_wr <= !srst && sc_hit && hwrite;
  end
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  // Direction updates on the same edge as the pad outputs, yet each check waits for it to settle
  a_pull_out_off: assert property ($past(output_enable) == output_enable |->
    (pull_on & output_enable) == 8'h00) else $error("pull on an output pin");
  a_pull_down_pull: assert property ((pull_down & ~pull_on) == 8'h00)
    else $error("pull-down without pull enable");
  a_pull_down_pins: assert property (pull_down[7:4] == 4'h0)
    else $error("pull-down on a pin without interrupt");
  a_slew_out: assert property ($past(output_enable) == output_enable |->
    (slew_on & ~output_enable) == 8'h00) else $error("slew on an input pin");
  a_drive_out: assert property ($past(output_enable) == output_enable |->
    (drive_high & ~output_enable) == 8'h00) else $error("drive on an input pin");
  a_ack_reads_zero: assert property (sc_rd |-> hrdata[2] == 1'b0 && hrdata[7:4] == 4'h0)
    else $error("acknowledge bit read as one");
  a_enable_gate: assert property (sc_wr && !hwdata[1] |-> ##2 !pin_irq_request)
    else $error("request with enable clear");
  cover property (sc_wr && hwdata[2]);
  cover property ($rose(pin_irq_request));
  cover property (pull_down != 8'h00);
endmodule
bind pbp_port_b pbp_port_b_checker i_chk (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .output_enable(output_enable), .pull_on(pull_on),
  .pull_down(pull_down), .slew_on(slew_on), .drive_high(drive_high),
  .pin_irq_request(pin_irq_request));

// file: bench/tb_top.sv
// Bench for port B pads and pin interrupt: pad table, then reset and irq tests.
// Assumes the pin model and the bound checker.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module tb_top;
  typedef struct packed {
    logic [7:0] dir, pe, se, ds, sel, pol, e_pu, e_pd, e_sl, e_dr;
  } pbp_row_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = pbp_pkg::HSIZE_WORD;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] ext_en = 8'h00;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, pin_irq_request, irq;
  logic [7:0] pin_in, output_enable, pull_on, pull_down, slew_on, drive_high;
  int n_mismatch = 0;
  int checked = 0;
  pbp_row_t rows [4] = '{
    '{8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00},
    '{8'hf0, 8'hff, 8'hff, 8'h55, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'hf0, 8'h50},
    '{8'h0f, 8'ha5, 8'h3c, 8'hff, 8'h05, 8'h0f, 8'ha0, 8'h00, 8'h0c, 8'h0f},
    '{8'h00, 8'h0f, 8'h00, 8'h00, 8'h06, 8'h03, 8'h0f, 8'h02, 8'h00, 8'h00}};
  always #25 clk = ~clk;
  pbp_port_b i_dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
    .output_enable(output_enable), .pull_on(pull_on), .pull_down(pull_down),
    .slew_on(slew_on), .drive_high(drive_high), .pin_irq_request(pin_irq_request), .irq(irq));
  pbp_pin_model i_pins (.clk(clk), .ext_val(ext_val), .ext_en(ext_en), .pull_on(pull_on),
    .pull_down(pull_down), .pin_in(pin_in));
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= pbp_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(a, 1'b0, 32'h0);
    `CHK(n, e, q)
  endtask
  task automatic do_reset;
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("Counts: %0d comparisons, %0d mismatches", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    @(posedge clk);
    do_reset();
    foreach (rows[i]) begin
      bus(pbp_pkg::DIRECTION_OFS, 1'b1, {24'h0, rows[i].dir});
      bus(pbp_pkg::PULL_ENABLE_OFS, 1'b1, {24'h0, rows[i].pe});
      bus(pbp_pkg::SLEW_ENABLE_OFS, 1'b1, {24'h0, rows[i].se});
      bus(pbp_pkg::DRIVE_SELECT_OFS, 1'b1, {24'h0, rows[i].ds});
      bus(pbp_pkg::PIN_SELECT_OFS, 1'b1, {24'h0, rows[i].sel});
      bus(pbp_pkg::POLARITY_OFS, 1'b1, {24'h0, rows[i].pol});
      rd_chk(pbp_pkg::DRIVE_SELECT_OFS, {24'h0, rows[i].ds}, "drive reg");
      `CHK("output_enable", rows[i].dir, output_enable)
      `CHK("pull_on", rows[i].e_pu, pull_on)
      `CHK("pull_down", rows[i].e_pd, pull_down)
      `CHK("slew_on", rows[i].e_sl, slew_on)
      `CHK("drive_high", rows[i].e_dr, drive_high)
      $display("Test pad row %0d done", i);
    end
    ext_en <= 8'h0f;
    do_reset();
    `CHK("reset pads", 40'h0, {output_enable, pull_on, pull_down, slew_on, drive_high})
    rd_chk(pbp_pkg::STATUS_CONTROL_OFS, 32'h0, "sc reset");
    rd_chk(pbp_pkg::PULL_ENABLE_OFS, 32'h0, "pull reset");
    rd_chk(8'h40, 32'h0, "unmapped");
    $display("Test reset done");
    // Polarity first: a low pin under default polarity would flag at once
    bus(pbp_pkg::POLARITY_OFS, 1'b1, 32'h1);
    bus(pbp_pkg::PIN_SELECT_OFS, 1'b1, 32'h1);
    bus(pbp_pkg::EVENT_MASK_OFS, 1'b1, 32'h1);
    bus(pbp_pkg::STATUS_CONTROL_OFS, 1'b1, 32'h2);
    ext_val <= 8'h01;
    repeat (8) @(posedge clk);
    `CHK("request", 1'b1, pin_irq_request)
    `CHK("irq", 1'b1, irq)
    rd_chk(pbp_pkg::STATUS_CONTROL_OFS, 32'h0a, "sc edge");
    // Pin still high: in edge mode the acknowledge must win
    bus(pbp_pkg::STATUS_CONTROL_OFS, 1'b1, 32'h6);
    rd_chk(pbp_pkg::STATUS_CONTROL_OFS, 32'h02, "sc ack");
    `CHK("request off", 1'b0, pin_irq_request)
    bus(pbp_pkg::EVENT_STATUS_OFS, 1'b1, 32'h3);
    repeat (2) @(posedge clk);
    `CHK("irq clear", 1'b0, irq)
    bus(pbp_pkg::STATUS_CONTROL_OFS, 1'b1, 32'ha);
    rd_chk(pbp_pkg::STATUS_CONTROL_OFS, 32'h02, "sc flag write");
    $display("Test edge irq done");
    bus(pbp_pkg::STATUS_CONTROL_OFS, 1'b1, 32'h3);
    repeat (6) @(posedge clk);
    bus(pbp_pkg::STATUS_CONTROL_OFS, 1'b1, 32'h7);
    rd_chk(pbp_pkg::STATUS_CONTROL_OFS, 32'h0b, "sc level ack");
    bus(pbp_pkg::EVENT_MASK_OFS, 1'b1, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    bus(pbp_pkg::EVENT_MASK_OFS, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq unmasked", 1'b1, irq)
    bus(pbp_pkg::STATUS_CONTROL_OFS, 1'b1, 32'h1);
    repeat (3) @(posedge clk);
    `CHK("request gated", 1'b0, pin_irq_request)
    ext_val <= 8'h00;
    repeat (8) @(posedge clk);
    bus(pbp_pkg::STATUS_CONTROL_OFS, 1'b1, 32'h7);
    rd_chk(pbp_pkg::STATUS_CONTROL_OFS, 32'h03, "sc level clear");
    $display("Test level irq done");
    bus(pbp_pkg::PIN_SELECT_OFS, 1'b1, 32'h0);
    bus(pbp_pkg::POLARITY_OFS, 1'b1, 32'h0);
    bus(pbp_pkg::STATUS_CONTROL_OFS, 1'b1, 32'h2);
    ext_val <= 8'h01;
    repeat (8) @(posedge clk);
    `CHK("request unselected", 1'b0, pin_irq_request)
    rd_chk(pbp_pkg::STATUS_CONTROL_OFS, 32'h02, "sc unselected");
    bus(pbp_pkg::PIN_SELECT_OFS, 1'b1, 32'h1);
    ext_val <= 8'h00;
    repeat (8) @(posedge clk);
    rd_chk(pbp_pkg::STATUS_CONTROL_OFS, 32'h0a, "sc falling");
    $display("Test falling irq done");
    print_verdict();
  end
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
endmodule

// file: rtl/pbp_pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module pbp_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pin
  input wire logic pin_in,
  // Filtered level
  output logic level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // First stage read only by the second
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      level <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level <= s3_reg;
    end
  end
endmodule

// file: rtl/pbp_pkg.sv
// Package for the port B pad control and pin interrupt block.
// Assumes a 32-bit AHB-Lite slave, one word per register.
package pbp_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] PULL_ENABLE_OFS = 8'h00;
  localparam logic [7:0] SLEW_ENABLE_OFS = 8'h04;
  localparam logic [7:0] DRIVE_SELECT_OFS = 8'h08;
  localparam logic [7:0] STATUS_CONTROL_OFS = 8'h0c;
  localparam logic [7:0] PIN_SELECT_OFS = 8'h10;
  localparam logic [7:0] POLARITY_OFS = 8'h14;
  localparam logic [7:0] DIRECTION_OFS = 8'h18;
  localparam logic [7:0] EVENT_STATUS_OFS = 8'h1c;
  localparam logic [7:0] EVENT_MASK_OFS = 8'h20;
  // ----------------------------------------
  // Status and control fields
  // ----------------------------------------
  localparam int FLAG_BIT = 3;
  localparam int ACK_BIT = 2;
  localparam int ENABLE_BIT = 1;
  localparam int MODE_BIT = 0;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] PAD_RESET = 8'h00;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [7:0] SC_RESET = 8'h00;
  // ----------------------------------------
  // Sizes and bus encodings
  // ----------------------------------------
  localparam int PORT_WIDTH = 8;
  localparam int IRQ_PINS = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// file: rtl/pbp_port_b.sv
// Port B pad control and pin interrupt logic with AHB-Lite registers.
// Assumes a single AHB-Lite master, word transfers, pins async to clk.
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - A set pull-enable bit turns on the pull device of its pin and a clear bit turns it off.
// - On a pin set as output the pull-enable bit is ignored and the pull stays off.
// - A pull-down is chosen only for a selected interrupt pin with rising polarity, else pull-up.
// - A set slew bit enables slew control on its pin, with no effect while the pin is an input.
// - A set drive bit selects high drive on its pin, ignored while the pin is an input.
// - Status bit 3 reads one once a pin interrupt is detected and ignores software writes.
// - Writing one to bit 2 clears the flag unless a detection in the same cycle wins; nothing is stored and the bit reads zero.
// - Enable bit 1 gates the flag onto the interrupt request.
// - Mode bit 0 picks edge-only detection when zero and edge-and-level when one.
// - A set pin-select bit makes its pin an interrupt source, a clear bit excludes it.
// - Polarity zero detects falling or low with pull-up, one detects rising or high with pull-down.
// - Direction bits make each pin an input or an output with driver on.
module pbp_port_b (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins
  input wire logic [7:0] pin_in,
  // Pad controls
  output logic [7:0] output_enable,
  output logic [7:0] pull_on,
  output logic [7:0] pull_down,
  output logic [7:0] slew_on,
  output logic [7:0] drive_high,
  // Interrupts
  output logic pin_irq_request,
  output logic irq
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] pull_enable_bits_reg;
  logic [7:0] slew_enable_bits_reg;
  logic [7:0] drive_select_bits_reg;
  logic [7:0] direction_bits_reg;
  logic [3:0] irq_pin_select_bits_reg;
  logic [3:0] irq_polarity_bits_reg;
  logic pin_irq_flag_reg;
  logic pin_irq_enable_reg;
  logic detect_mode_reg;
  logic [1:0] event_status_reg;
  logic [1:0] event_mask_reg;
  logic [3:0] prev_active_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;

  // Detection and bus decode nets
  logic [7:0] pin_level;
  logic [3:0] active_now;
  logic edge_hit;
  logic level_hit;
  logic detect;
  logic ack_wr;
  logic wr_take;
  logic rd_take;
  logic [7:0] rd_addr;
  logic [7:0] sc_read;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < pbp_pkg::PORT_WIDTH; gi++) begin : g_sync
      pbp_pin_sync u_sync (
        .clk(clk),
        .srst(srst),
        .pin_in(pin_in[gi]),
        .level(pin_level[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign wr_take = hsel && hready && hwrite &&
                   (htrans == pbp_pkg::HTRANS_NONSEQ || htrans == pbp_pkg::HTRANS_SEQ);
  assign rd_take = hsel && hready && !hwrite &&
                   (htrans == pbp_pkg::HTRANS_NONSEQ || htrans == pbp_pkg::HTRANS_SEQ);
  assign rd_addr = haddr[7:0];

  // Write data arrives a cycle after the address
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= wr_take;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // One strobe per register; address held over from the address phase
  logic wr_pull;
  logic wr_slew;
  logic wr_drive;
  logic wr_dir;
  logic wr_sel;
  logic wr_pol;
  logic wr_sc;
  logic wr_event;
  logic wr_mask;

  assign wr_pull = wr_pend_reg && (wr_addr_reg == pbp_pkg::PULL_ENABLE_OFS);
  assign wr_slew = wr_pend_reg && (wr_addr_reg == pbp_pkg::SLEW_ENABLE_OFS);
  assign wr_drive = wr_pend_reg && (wr_addr_reg == pbp_pkg::DRIVE_SELECT_OFS);
  assign wr_dir = wr_pend_reg && (wr_addr_reg == pbp_pkg::DIRECTION_OFS);
  assign wr_sel = wr_pend_reg && (wr_addr_reg == pbp_pkg::PIN_SELECT_OFS);
  assign wr_pol = wr_pend_reg && (wr_addr_reg == pbp_pkg::POLARITY_OFS);
  assign wr_sc = wr_pend_reg && (wr_addr_reg == pbp_pkg::STATUS_CONTROL_OFS);
  assign wr_event = wr_pend_reg && (wr_addr_reg == pbp_pkg::EVENT_STATUS_OFS);
  assign wr_mask = wr_pend_reg && (wr_addr_reg == pbp_pkg::EVENT_MASK_OFS);

  always_ff @(posedge clk) begin
    if (srst) begin
      pull_enable_bits_reg <= pbp_pkg::PAD_RESET;
    end else if (wr_pull) begin
      pull_enable_bits_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      slew_enable_bits_reg <= pbp_pkg::PAD_RESET;
    end else if (wr_slew) begin
      slew_enable_bits_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      drive_select_bits_reg <= pbp_pkg::PAD_RESET;
    end else if (wr_drive) begin
      drive_select_bits_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      direction_bits_reg <= pbp_pkg::PAD_RESET;
    end else if (wr_dir) begin
      direction_bits_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_pin_select_bits_reg <= pbp_pkg::SEL_RESET;
    end else if (wr_sel) begin
      irq_pin_select_bits_reg <= hwdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_polarity_bits_reg <= pbp_pkg::SEL_RESET;
    end else if (wr_pol) begin
      irq_polarity_bits_reg <= hwdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_irq_enable_reg <= 1'b0;
      detect_mode_reg <= 1'b0;
    end else if (wr_sc) begin
      pin_irq_enable_reg <= hwdata[pbp_pkg::ENABLE_BIT];
      detect_mode_reg <= hwdata[pbp_pkg::MODE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      event_mask_reg <= 2'h0;
    end else if (wr_mask) begin
      event_mask_reg <= hwdata[1:0];
    end
  end

  // ----------------------------------------
  // Pin interrupt detection
  // ----------------------------------------
  // Active level per selected pin after polarity
  assign active_now = (pin_level[3:0] ~^ irq_polarity_bits_reg) & irq_pin_select_bits_reg;
  assign edge_hit = |(active_now & ~prev_active_reg);
  assign level_hit = detect_mode_reg && (|active_now);
  assign detect = edge_hit || level_hit;
  assign ack_wr = wr_sc && hwdata[pbp_pkg::ACK_BIT];

  // Newly selected pins already active count as an edge; avoids a missed first edge
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_active_reg <= 4'h0;
    end else begin
      prev_active_reg <= active_now;
    end
  end

  // Detection wins over the acknowledge in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_irq_flag_reg <= 1'b0;
    end else if (detect) begin
      pin_irq_flag_reg <= 1'b1;
    end else if (ack_wr) begin
      pin_irq_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Event status and mask
  // ----------------------------------------
  // Bit 0 flag rising, bit 1 acknowledge refused by a still-active level
  always_ff @(posedge clk) begin
    if (srst) begin
      event_status_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0 && detect && !pin_irq_flag_reg) || (i == 1 && ack_wr && level_hit)) begin
          event_status_reg[i] <= 1'b1;
        end else if (wr_event && hwdata[i]) begin
          event_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_status_reg & event_mask_reg);
    end
  end

  // Registered request, one cycle behind the flag
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_irq_request <= 1'b0;
    end else begin
      pin_irq_request <= pin_irq_flag_reg && pin_irq_enable_reg;
    end
  end

  // ----------------------------------------
  // Pad controls
  // ----------------------------------------
  // All pad controls update on the same edge, so they never disagree
  always_ff @(posedge clk) begin
    if (srst) begin
      output_enable <= 8'h00;
    end else begin
      output_enable <= direction_bits_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pull_on <= 8'h00;
    end else begin
      pull_on <= pull_enable_bits_reg & ~direction_bits_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pull_down <= 8'h00;
    end else begin
      pull_down <= pull_enable_bits_reg & ~direction_bits_reg &
                   {4'h0, irq_pin_select_bits_reg & irq_polarity_bits_reg};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      slew_on <= 8'h00;
    end else begin
      slew_on <= slew_enable_bits_reg & direction_bits_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      drive_high <= 8'h00;
    end else begin
      drive_high <= drive_select_bits_reg & direction_bits_reg;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Acknowledge reads zero; flag shows live state
  assign sc_read = {4'h0, pin_irq_flag_reg, 1'b0, pin_irq_enable_reg, detect_mode_reg};

  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      case (rd_addr)
        pbp_pkg::PULL_ENABLE_OFS: hrdata <= {24'h0, pull_enable_bits_reg};
        pbp_pkg::SLEW_ENABLE_OFS: hrdata <= {24'h0, slew_enable_bits_reg};
        pbp_pkg::DRIVE_SELECT_OFS: hrdata <= {24'h0, drive_select_bits_reg};
        pbp_pkg::STATUS_CONTROL_OFS: hrdata <= {24'h0, sc_read};
        pbp_pkg::PIN_SELECT_OFS: hrdata <= {28'h0, irq_pin_select_bits_reg};
        pbp_pkg::POLARITY_OFS: hrdata <= {28'h0, irq_polarity_bits_reg};
        pbp_pkg::DIRECTION_OFS: hrdata <= {24'h0, direction_bits_reg};
        pbp_pkg::EVENT_STATUS_OFS: hrdata <= {30'h0, event_status_reg};
        pbp_pkg::EVENT_MASK_OFS: hrdata <= {30'h0, event_mask_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
